// ==== pkg/dfc_pkg.sv ====
package dfc_pkg;
    // register indices on the register port
    localparam logic [3:0] ADDR_GRAN_CTL = 4'h0;
    localparam logic [3:0] ADDR_PTE = 4'h2;
    localparam logic [3:0] ADDR_PTE_HOLD = 4'h3;
    localparam logic [3:0] ADDR_FAULT_STAT = 4'h4;
    localparam logic [3:0] ADDR_FAULT_VA = 4'h6;
    localparam logic [3:0] ADDR_BUS_ADDR = 4'h9;
    localparam logic [3:0] ADDR_BUS_STAT = 4'hA;
    localparam logic [3:0] ADDR_INSTR_HOLD = 4'hD;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'hE;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hF;
    // granularity field position
    localparam int HINT_LSB = 5;
    localparam logic [1:0] HINT_RESET = 2'h0;
    // page size as log2 of bytes
    localparam logic [4:0] PAGE_8K = 5'h0D;
    localparam logic [4:0] PAGE_64K = 5'h10;
    localparam logic [4:0] PAGE_512K = 5'h13;
    localparam logic [4:0] PAGE_4M = 5'h16;
    // entry bits kept in storage (valid bit 0 is never stored)
    localparam logic [63:0] PTE_KEEP_MASK = 64'hFFFFFFFF_0000FF7E;
    // fault status field positions
    localparam int FS_OPC_LSB = 9;
    localparam int FS_REG_LSB = 4;
    localparam int FS_WR_FAULT = 3;
    localparam int FS_FOR = 2;
    localparam int FS_VIOL = 1;
    localparam int FS_WR = 0;
    // bus status field positions
    localparam int BS_CMD_LSB = 4;
    localparam int BS_FATAL1 = 7;
    // bus error address field positions
    localparam int BA_ADDR_LSB = 5;
    localparam int BA_SUB_LSB = 2;
    // cycle type codes for which the low subfield is captured
    localparam logic [2:0] CMD_READ_BLOCK = 3'h2;
    localparam logic [2:0] CMD_LOAD_LOCKED = 3'h3;
    // interrupt status bits
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_BUS = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // data-stream fault report from the address unit
    typedef struct packed {
        logic [63:0] va;
        logic [5:0] opcode;
        logic [4:0] reg_field;
        logic is_write;
        logic pte_wr_fault;
        logic pte_for;
        logic violation;
        logic mm_error;
        logic tb_miss;
    } dfc_fault_type;

    // external bus error report
    typedef struct packed {
        logic [33:2] addr;
        logic [2:0] cycle_type;
        logic hard_err;
        logic soft_err;
        logic tag_par_err;
        logic tag_ctl_par_err;
    } dfc_bus_err_type;
endpackage

// ==== verilog/dfc_regs.sv ====
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
// Functional notes
// - granularity field selects instruction and data page sizes
// - 32 entries, target chosen by not-last-used
// - entry writes masked, valid bit not stored
// - entry read copies to holding, second read returns
// - instruction holding overwritten on every instruction access
// - fault status and address lock until address read
// - fault status updates on error/miss when unlocked or in the cycle of the address read
// - reset leaves fault status unlocked
// - opcode bits 14:9, register field bits 8:4
// - fault-on-write and fault-on-read flags from entry
// - access violation and write flags recorded
// - bus error address read unlocks address and status
// - address field holds external lines 33:5
// - low subfield zero except block read/locked load
// - bus status latches cycle type on error
// - bus status and address lock while flags set
module dfc_regs
    import dfc_pkg::*;
#(
    parameter int ENTRIES = 32
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [63:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [63:0] reg_rdata_out,
    // translation buffer side
    input wire logic [$clog2(ENTRIES)-1:0] tlb_read_index_in,
    input wire logic tlb_hit_in,
    input wire logic [$clog2(ENTRIES)-1:0] tlb_hit_index_in,
    output logic [4:0] itb_page_size_out,
    output logic [4:0] dtb_page_size_out,
    output logic [$clog2(ENTRIES)-1:0] tlb_write_index_out,
    // instruction buffer access reports
    input wire logic instr_access_in,
    input wire logic [63:0] instr_access_data_in,
    // capture events
    input wire logic fault_valid_in,
    input wire dfc_pkg::dfc_fault_type fault_in,
    input wire logic bus_err_valid_in,
    input wire dfc_pkg::dfc_bus_err_type bus_err_in,
    // status and interrupt
    output logic fault_locked_out,
    output logic bus_err_locked_out,
    output logic irq_out
);

    localparam int IW = $clog2(ENTRIES);

    initial begin
        if (ENTRIES < 2 || (1 << IW) != ENTRIES) begin
            $error("ENTRIES must be a power of two, at least 2");
        end
    end

    ////////////////////////////////////////////////////////////////
    // register decode

    logic wr_gran_ctl;
    logic wr_pte;
    logic rd_pte;
    logic rd_fault_va;
    logic rd_bus_addr;
    logic wr_irq_stat;
    logic wr_irq_mask;

    // one strobe per register action
    assign wr_gran_ctl = reg_wr_in && reg_addr_in == ADDR_GRAN_CTL;
    assign wr_pte = reg_wr_in && reg_addr_in == ADDR_PTE;
    assign rd_pte = reg_rd_in && reg_addr_in == ADDR_PTE;
    assign rd_fault_va = reg_rd_in && reg_addr_in == ADDR_FAULT_VA;
    assign rd_bus_addr = reg_rd_in && reg_addr_in == ADDR_BUS_ADDR;
    assign wr_irq_stat = reg_wr_in && reg_addr_in == ADDR_IRQ_STAT;
    assign wr_irq_mask = reg_wr_in && reg_addr_in == ADDR_IRQ_MASK;

    ////////////////////////////////////////////////////////////////
    // granularity control

    logic [1:0] gran_hint;

    // maps the hint to data page size
    function automatic logic [4:0] dtb_size(input logic [1:0] gh);
        case (gh)
            2'h0: dtb_size = PAGE_8K;
            2'h1: dtb_size = PAGE_64K;
            2'h2: dtb_size = PAGE_512K;
            default: dtb_size = PAGE_4M;
        endcase
    endfunction

    // write-only control field
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            gran_hint <= HINT_RESET;
        end else if (wr_gran_ctl) begin
            gran_hint <= reg_wdata_in[HINT_LSB +: 2];
        end
    end

    // page sizes seen by both buffers
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            itb_page_size_out <= PAGE_8K;
            dtb_page_size_out <= PAGE_8K;
        end else begin
            itb_page_size_out <= (gran_hint == 2'h3) ? PAGE_4M
                                                     : PAGE_8K;
            dtb_page_size_out <= dtb_size(gran_hint);
        end
    end

    ////////////////////////////////////////////////////////////////
    // entry storage and replacement

    logic [63:0] entry_mem [ENTRIES];
    logic [IW-1:0] victim_ptr;
    logic [IW-1:0] last_used;
    logic [IW-1:0] next_target;
    logic [63:0] pte_hold;
    logic [63:0] instr_hold;

    // skip the entry used most recently
    assign next_target = (victim_ptr == last_used) ? victim_ptr + 1'b1
                                                   : victim_ptr;
    assign tlb_write_index_out = next_target;

    // replacement pointers
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            victim_ptr <= '0;
            last_used <= '1;
        end else if (wr_pte) begin
            victim_ptr <= next_target + 1'b1;
            last_used <= next_target;
        end else if (tlb_hit_in) begin
            last_used <= tlb_hit_index_in;
        end
    end

    // entry array, masked fields only
    genvar gi;
    generate
        for (gi = 0; gi < ENTRIES; gi++) begin : g_entry
            always_ff @(posedge core_clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    entry_mem[gi] <= '0;
                end else if (wr_pte && next_target == gi) begin
                    entry_mem[gi] <= reg_wdata_in & PTE_KEEP_MASK;
                end
            end
        end
    endgenerate

    // first read step fills the holding register
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pte_hold <= '0;
        end else if (rd_pte) begin
            pte_hold <= entry_mem[tlb_read_index_in];
        end
    end

    // instruction holding follows every access
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            instr_hold <= '0;
        end else if (instr_access_in) begin
            instr_hold <= instr_access_data_in;
        end
    end

    ////////////////////////////////////////////////////////////////
    // data-stream fault capture

    logic fault_lock;
    logic fault_take;
    logic [14:0] fault_stat;
    logic [63:0] fault_va;

    // read in the same cycle frees the pair for this event
    assign fault_take = fault_valid_in
                        && (fault_in.mm_error || fault_in.tb_miss)
                        && (!fault_lock || rd_fault_va);

    // lock flag, cleared at reset and by the address read
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fault_lock <= 1'b0;
        end else if (fault_take) begin
            fault_lock <= 1'b1;
        end else if (rd_fault_va) begin
            fault_lock <= 1'b0;
        end
    end

    // captured status and address, never written by software
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fault_stat <= '0;
            fault_va <= '0;
        end else if (fault_take) begin
            fault_stat[FS_OPC_LSB +: 6] <= fault_in.opcode;
            fault_stat[FS_REG_LSB +: 5] <= fault_in.reg_field;
            fault_stat[FS_WR_FAULT] <= fault_in.is_write
                                       && fault_in.pte_wr_fault;
            fault_stat[FS_FOR] <= !fault_in.is_write
                                  && fault_in.pte_for;
            fault_stat[FS_VIOL] <= fault_in.violation;
            fault_stat[FS_WR] <= fault_in.is_write;
            fault_va <= fault_in.va;
        end
    end

    ////////////////////////////////////////////////////////////////
    // external bus error capture

    logic bus_lock;
    logic bus_any;
    logic bus_take;
    logic [7:0] bus_stat;
    logic [33:2] bus_addr;

    assign bus_any = bus_err_in.hard_err || bus_err_in.soft_err
                     || bus_err_in.tag_par_err
                     || bus_err_in.tag_ctl_par_err;
    assign bus_take = bus_err_valid_in && bus_any
                      && (!bus_lock || rd_bus_addr);

    // lock flag for status low byte and address
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bus_lock <= 1'b0;
        end else if (bus_take) begin
            bus_lock <= 1'b1;
        end else if (rd_bus_addr) begin
            bus_lock <= 1'b0;
        end
    end

    // status low byte: flags, cycle type, second-error mark
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bus_stat <= '0;
        end else if (bus_take) begin
            bus_stat <= {1'b0, bus_err_in.cycle_type,
                         bus_err_in.tag_ctl_par_err,
                         bus_err_in.tag_par_err,
                         bus_err_in.soft_err,
                         bus_err_in.hard_err};
        end else if (rd_bus_addr) begin
            bus_stat <= '0;
        end else if (bus_err_valid_in && bus_any) begin
            bus_stat[BS_FATAL1] <= 1'b1;
        end
    end

    // captured address; low subfield only for two cycle types
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bus_addr <= '0;
        end else if (bus_take) begin
            bus_addr[33:5] <= bus_err_in.addr[33:5];
            if (bus_err_in.cycle_type == CMD_READ_BLOCK
                || bus_err_in.cycle_type == CMD_LOAD_LOCKED) begin
                bus_addr[4:2] <= bus_err_in.addr[4:2];
            end else begin
                bus_addr[4:2] <= 3'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // interrupt status and mask

    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [1:0] irq_set;

    assign irq_set = {bus_take, fault_take};

    // sticky bits, write one to clear, set wins
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_stat <= IRQ_RESET;
        end else begin
            irq_stat <= irq_set | (irq_stat
                        & ~(wr_irq_stat ? reg_wdata_in[1:0] : 2'h0));
        end
    end

    // mask register
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_mask <= IRQ_RESET;
        end else if (wr_irq_mask) begin
            irq_mask <= reg_wdata_in[1:0];
        end
    end

    assign irq_out = |(irq_stat & irq_mask);
    assign fault_locked_out = fault_lock;
    assign bus_err_locked_out = bus_lock;

    ////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe

    logic [63:0] next_rdata;

    // selects read value; write-only and unmapped read zero
    always_comb begin
        next_rdata = '0;
        case (reg_addr_in)
            ADDR_PTE_HOLD: next_rdata = pte_hold;
            ADDR_FAULT_STAT: next_rdata = {49'h0, fault_stat};
            ADDR_FAULT_VA: next_rdata = fault_va;
            ADDR_BUS_ADDR: next_rdata = {30'h0, bus_addr, 2'h0};
            ADDR_BUS_STAT: next_rdata = {56'h0, bus_stat};
            ADDR_INSTR_HOLD: next_rdata = instr_hold;
            ADDR_IRQ_STAT: next_rdata = {62'h0, irq_stat};
            ADDR_IRQ_MASK: next_rdata = {62'h0, irq_mask};
            default: next_rdata = '0;
        endcase
    end

    // read data register
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            reg_rdata_out <= next_rdata;
        end else begin
            reg_rdata_out <= '0;
        end
    end

endmodule

// ==== test/dfc_regs_monitor.sv ====
`timescale 1ns/1ps
module dfc_regs_monitor
    import dfc_pkg::*;
#(
    parameter int ENTRIES = 32
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [63:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [63:0] reg_rdata_out,
    // translation buffer side
    input wire logic [4:0] itb_page_size_out,
    input wire logic [4:0] dtb_page_size_out,
    input wire logic [$clog2(ENTRIES)-1:0] tlb_write_index_out,
    // capture events
    input wire logic fault_valid_in,
    input wire dfc_pkg::dfc_fault_type fault_in,
    input wire logic bus_err_valid_in,
    input wire dfc_pkg::dfc_bus_err_type bus_err_in,
    // status
    input wire logic fault_locked_out,
    input wire logic bus_err_locked_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);

    // unlocking reads decoded once
    logic va_rd;
    logic ba_rd;
    assign va_rd = reg_rd_in && reg_addr_in == ADDR_FAULT_VA;
    assign ba_rd = reg_rd_in && reg_addr_in == ADDR_BUS_ADDR;

    // capture events after which the lock flag must be set
    sequence fault_take;
        !fault_locked_out && fault_valid_in
            && (fault_in.mm_error || fault_in.tb_miss);
    endsequence
    sequence bus_take;
        bus_err_valid_in && (bus_err_in.hard_err || bus_err_in.soft_err
            || bus_err_in.tag_par_err || bus_err_in.tag_ctl_par_err);
    endsequence

    rdata_idle_a: assert property (
        !reg_rd_in |=> reg_rdata_out == 64'h0)
        else $error("read data not zero outside a read answer");
    fault_lock_set_a: assert property (
        fault_take |=> fault_locked_out)
        else $error("fault report not captured while unlocked");
    fault_lock_hold_a: assert property (
        fault_locked_out && !va_rd |=> fault_locked_out)
        else $error("fault lock dropped without address read");
    fault_unlock_a: assert property (
        fault_locked_out && va_rd && !fault_valid_in
        |=> !fault_locked_out)
        else $error("fault address read did not unlock");
    fault_ignore_a: assert property (
        !fault_locked_out && !(fault_valid_in
        && (fault_in.mm_error || fault_in.tb_miss)) |=> !fault_locked_out)
        else $error("fault status locked without error or miss");
    bus_lock_set_a: assert property (
        bus_take |=> bus_err_locked_out)
        else $error("bus error not latched");
    bus_unlock_a: assert property (
        bus_err_locked_out && ba_rd && !bus_err_valid_in
        |=> !bus_err_locked_out)
        else $error("bus address read did not unlock");
    page_large_a: assert property (
        reg_wr_in && reg_addr_in == ADDR_GRAN_CTL
        && reg_wdata_in[HINT_LSB+:2] == 2'h3 |=> ##[0:1]
        (itb_page_size_out == PAGE_4M && dtb_page_size_out == PAGE_4M))
        else $error("largest granularity not applied");
    victim_moves_a: assert property (
        reg_wr_in && reg_addr_in == ADDR_PTE
        |=> tlb_write_index_out != $past(tlb_write_index_out))
        else $error("entry write left the target unchanged");
endmodule

// ==== test/dfc_core_model.sv ====
`timescale 1ns/1ps
module dfc_core_model
    import dfc_pkg::*;
(
    // clock
    input wire logic core_clk_in,
    // reports to the register group
    output logic fault_valid_out,
    output dfc_pkg::dfc_fault_type fault_out,
    output logic bus_err_valid_out,
    output dfc_pkg::dfc_bus_err_type bus_err_out,
    output logic instr_access_out,
    output logic [63:0] instr_data_out,
    output logic tlb_hit_out,
    output logic [4:0] tlb_hit_index_out
);
    // idle pipeline: no reports
    initial begin
        fault_valid_out = 1'b0;
        fault_out = '0;
        bus_err_valid_out = 1'b0;
        bus_err_out = '0;
        instr_access_out = 1'b0;
        instr_data_out = 64'h0;
        tlb_hit_out = 1'b0;
        tlb_hit_index_out = 5'h0;
    end
    // one-cycle reports; released fields are scrambled, not held
    task automatic send_fault(input dfc_fault_type f);
        @(posedge core_clk_in);
        fault_valid_out <= 1'b1;
        fault_out <= f;
        @(posedge core_clk_in);
        fault_valid_out <= 1'b0;
        fault_out <= ~f;
    endtask
    task automatic send_bus(input dfc_bus_err_type b);
        @(posedge core_clk_in);
        bus_err_valid_out <= 1'b1;
        bus_err_out <= b;
        @(posedge core_clk_in);
        bus_err_valid_out <= 1'b0;
        bus_err_out <= ~b;
    endtask
    task automatic send_instr(input logic [63:0] v);
        @(posedge core_clk_in);
        instr_access_out <= 1'b1;
        instr_data_out <= v;
        @(posedge core_clk_in);
        instr_access_out <= 1'b0;
        instr_data_out <= ~v;
    endtask
    task automatic send_hit(input logic [4:0] i);
        @(posedge core_clk_in);
        tlb_hit_out <= 1'b1;
        tlb_hit_index_out <= i;
        @(posedge core_clk_in);
        tlb_hit_out <= 1'b0;
        tlb_hit_index_out <= ~i;
    endtask
endmodule

// ==== test/tb_dtb_fault_capture_regs.sv ====
`timescale 1ns/1ps
module tb_dtb_fault_capture_regs;
    import dfc_pkg::*;
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [63:0] reg_wdata_in = 64'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [4:0] tlb_read_index_in = 5'h0;
    logic [63:0] reg_rdata_out, instr_access_data_in, d;
    logic [4:0] itb_page_size_out, dtb_page_size_out, tlb_write_index_out;
    logic [4:0] tlb_hit_index_in, w, h;
    logic tlb_hit_in, instr_access_in, fault_valid_in, bus_err_valid_in;
    logic fault_locked_out, bus_err_locked_out, irq_out;
    dfc_fault_type fault_in, f, g;
    dfc_bus_err_type bus_err_in, b;
    int miscompares = 0;
    int n_tests = 0;
    // granularity rows: expected instruction and data page sizes
    logic [4:0] exp_i [4] = '{PAGE_8K, PAGE_8K, PAGE_8K, PAGE_4M};
    logic [4:0] exp_d [4] = '{PAGE_8K, PAGE_64K, PAGE_512K, PAGE_4M};

    always #50 core_clk_in = ~core_clk_in;

    dfc_regs #(.ENTRIES(32)) DUT (.core_clk_in, .resetn_in, .reg_addr_in,
        .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .tlb_read_index_in, .tlb_hit_in, .tlb_hit_index_in,
        .itb_page_size_out, .dtb_page_size_out, .tlb_write_index_out,
        .instr_access_in, .instr_access_data_in, .fault_valid_in,
        .fault_in, .bus_err_valid_in, .bus_err_in, .fault_locked_out,
        .bus_err_locked_out, .irq_out);
    dfc_core_model u_core (.core_clk_in, .fault_valid_out(fault_valid_in),
        .fault_out(fault_in), .bus_err_valid_out(bus_err_valid_in),
        .bus_err_out(bus_err_in), .instr_access_out(instr_access_in),
        .instr_data_out(instr_access_data_in), .tlb_hit_out(tlb_hit_in),
        .tlb_hit_index_out(tlb_hit_index_in));

    ////////////////////////////////////////////////////////////////////
    // compare, register cycles and verdict
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [63:0] v);
        @(posedge core_clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= v;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
        reg_wdata_in <= ~v;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [63:0] v);
        @(posedge core_clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1 v = reg_rdata_out;
    endtask
    task automatic test_done;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (5) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        #1 chk({63'h0, fault_locked_out}, 64'h0);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_GRAN_CTL, 64'(i) << HINT_LSB);
            repeat (2) @(posedge core_clk_in);
            #1 chk({59'h0, itb_page_size_out}, {59'h0, exp_i[i]});
            chk({59'h0, dtb_page_size_out}, {59'h0, exp_d[i]});
        end
        // entry write, replacement and two-step read
        w = tlb_write_index_out;
        wr(ADDR_PTE, 64'hFFFFFFFF_FFFFFFFF);
        h = tlb_write_index_out;
        u_core.send_hit(h);
        #1 chk({63'h0, tlb_write_index_out != h}, 64'h1);
        tlb_read_index_in <= w;
        rd(ADDR_PTE, d);
        chk(d, 64'h0);
        rd(ADDR_PTE_HOLD, d);
        chk(d, PTE_KEEP_MASK);
        u_core.send_instr(64'h1111);
        u_core.send_instr(64'h2222);
        rd(ADDR_INSTR_HOLD, d);
        chk(d, 64'h2222);
        // fault capture, lock, masked interrupt
        f = '0;
        f.va = 64'h0000_1234_5678_9ABC;
        f.opcode = 6'h2A;
        f.reg_field = 5'h13;
        {f.is_write, f.pte_wr_fault, f.pte_for, f.violation} = 4'hF;
        f.mm_error = 1'b1;
        g = '0;
        g.opcode = 6'h01;
        g.mm_error = 1'b1;
        u_core.send_fault(f);
        #1 chk({63'h0, irq_out}, 64'h0);
        wr(ADDR_FAULT_STAT, 64'h0);
        wr(ADDR_IRQ_MASK, 64'h3);
        chk({63'h0, irq_out}, 64'h1);
        u_core.send_fault(g);
        rd(ADDR_FAULT_STAT, d);
        chk(d, 64'h553B);
        rd(ADDR_FAULT_VA, d);
        chk(d, f.va);
        chk({63'h0, fault_locked_out}, 64'h0);
        wr(ADDR_IRQ_STAT, 64'h1);
        chk({63'h0, irq_out}, 64'h0);
        g.mm_error = 1'b0;
        u_core.send_fault(g);
        #1 chk({63'h0, fault_locked_out}, 64'h0);
        f = '0;
        f.opcode = 6'h3F;
        f.reg_field = 5'h1F;
        {f.pte_wr_fault, f.pte_for, f.tb_miss} = 3'h7;
        u_core.send_fault(f);
        rd(ADDR_FAULT_STAT, d);
        chk(d, 64'h7FF4);
        rd(ADDR_FAULT_VA, d);
        // bus error capture, lock and unlock
        b = '0;
        b.addr = 32'hDEAD_BEEF;
        b.cycle_type = 3'h5;
        b.hard_err = 1'b1;
        u_core.send_bus(b);
        rd(ADDR_BUS_STAT, d);
        chk(d, 64'h51);
        u_core.send_bus(~b);
        rd(ADDR_BUS_STAT, d);
        chk(d, 64'hD1);
        rd(ADDR_BUS_ADDR, d);
        chk(d, {30'h0, b.addr[33:5], 5'h0});
        chk({63'h0, bus_err_locked_out}, 64'h0);
        rd(ADDR_BUS_STAT, d);
        chk(d, 64'h0);
        b.cycle_type = CMD_READ_BLOCK;
        {b.hard_err, b.tag_par_err} = 2'h1;
        u_core.send_bus(b);
        rd(ADDR_BUS_ADDR, d);
        chk({d[63:5], 5'h0}, {30'h0, b.addr[33:5], 5'h0});
        rd(4'h7, d);
        chk(d, 64'h0);
        test_done();
    end

    // watchdog against a hung sequence
    initial begin
        repeat (5000) @(posedge core_clk_in);
        miscompares++;
        $display("ERROR %0t: run did not finish", $time);
        test_done();
    end
endmodule

bind dfc_regs dfc_regs_monitor #(.ENTRIES(ENTRIES)) u_mon (.core_clk_in,
    .resetn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .itb_page_size_out, .dtb_page_size_out,
    .tlb_write_index_out, .fault_valid_in, .fault_in, .bus_err_valid_in,
    .bus_err_in, .fault_locked_out, .bus_err_locked_out);
